// *** hw/pes_opt_framer.sv ***
// Optional-field section generator for a PES header carrying synchronous data
`timescale 1ns/1ps
`include "pes_opt_cfg.svh"

module pes_opt_framer (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input wire pes_opt_pkg::hdr_cfg_s cfg_in,
    input wire logic byte_ready_in,
    input wire logic [7:0] payload_byte_in,
    input wire logic payload_valid_in,
    input wire logic payload_last_in,
    output logic [7:0] byte_out,
    output logic byte_valid_out,
    output logic header_done_out,
    output logic rate_clamped_out
);

    pes_opt_pkg::hdr_state_e state;
    pes_opt_pkg::hdr_state_e next_state;
    logic [5:0] idx;
    logic [5:0] next_idx;
    pes_opt_pkg::hdr_latch_s hdr;
    pes_opt_pkg::hdr_latch_s next_hdr;
    logic [7:0] next_byte;
    logic next_valid;
    logic next_done;
    logic next_clamped;
    logic [15:0] prev_crc;
    logic prev_crc_valid;

    payload_crc16 u_crc (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .data_in(payload_byte_in),
        .valid_in(payload_valid_in),
        .last_in(payload_last_in),
        .prev_crc_out(prev_crc),
        .prev_valid_out(prev_crc_valid)
    );

    // Bytes in each item
    function automatic logic [5:0] item_len(input pes_opt_pkg::hdr_state_e st,
                                            input pes_opt_pkg::hdr_latch_s h);
        case (st)
            pes_opt_pkg::S_FLAGS: item_len = `ONE_BYTE;
            pes_opt_pkg::S_LEN: item_len = `ONE_BYTE;
            pes_opt_pkg::S_PTS: item_len = `PTS_BYTES;
            pes_opt_pkg::S_RATE: item_len = `RATE_BYTES;
            pes_opt_pkg::S_CRC: item_len = `CRC_BYTES;
            pes_opt_pkg::S_STUFF: item_len = h.stuff;
            default: item_len = `IDX_ZERO;
        endcase
    endfunction : item_len

    // Header data length over everything after the length byte
    function automatic logic [7:0] hdr_len(input pes_opt_pkg::hdr_latch_s h);
        logic [5:0] n;
        n = `PTS_BYTES + h.stuff;
        if (h.rate_on) begin
            n = n + `RATE_BYTES;
        end
        if (h.crc_on) begin
            n = n + `CRC_BYTES;
        end
        hdr_len = {2'h0, n};
    endfunction : hdr_len

    // Item following a given one, skipping absent groups
    function automatic pes_opt_pkg::hdr_state_e after(input pes_opt_pkg::hdr_state_e st,
                                                      input pes_opt_pkg::hdr_latch_s h);
        logic more_stuff;
        more_stuff = (h.stuff != `IDX_ZERO);
        case (st)
            pes_opt_pkg::S_FLAGS: after = pes_opt_pkg::S_LEN;
            pes_opt_pkg::S_LEN: after = pes_opt_pkg::S_PTS;
            pes_opt_pkg::S_PTS: begin
                if (h.rate_on) begin
                    after = pes_opt_pkg::S_RATE;
                end else if (h.crc_on) begin
                    after = pes_opt_pkg::S_CRC;
                end else begin
                    after = more_stuff ? pes_opt_pkg::S_STUFF : pes_opt_pkg::S_IDLE;
                end
            end
            pes_opt_pkg::S_RATE: begin
                if (h.crc_on) begin
                    after = pes_opt_pkg::S_CRC;
                end else begin
                    after = more_stuff ? pes_opt_pkg::S_STUFF : pes_opt_pkg::S_IDLE;
                end
            end
            pes_opt_pkg::S_CRC: begin
                after = more_stuff ? pes_opt_pkg::S_STUFF : pes_opt_pkg::S_IDLE;
            end
            default: after = pes_opt_pkg::S_IDLE;
        endcase
    endfunction : after

    // Byte value at a position of the header
    function automatic logic [7:0] byte_at(input pes_opt_pkg::hdr_state_e st,
                                           input logic [5:0] i,
                                           input pes_opt_pkg::hdr_latch_s h);
        byte_at = 8'h00;
        case (st)
            pes_opt_pkg::S_FLAGS: begin
                // Timestamp flags, clock ref, rate, trick, copy info, CRC, extension
                byte_at = {`PTS_ONLY_FLAGS, `FLAG_OFF, h.rate_on, `FLAG_OFF, `FLAG_OFF,
                           h.crc_on, `FLAG_OFF};
            end
            pes_opt_pkg::S_LEN: byte_at = hdr_len(h);
            pes_opt_pkg::S_PTS: begin
                case (i)
                    `IDX_ZERO: byte_at = {`PTS_PREFIX, h.pts[32:30], `MARKER_ONE};
                    `IDX_ONE: byte_at = h.pts[29:22];
                    `IDX_TWO: byte_at = {h.pts[21:15], `MARKER_ONE};
                    `IDX_THREE: byte_at = h.pts[14:7];
                    default: byte_at = {h.pts[6:0], `MARKER_ONE};
                endcase
            end
            pes_opt_pkg::S_RATE: begin
                case (i)
                    `IDX_ZERO: byte_at = {`MARKER_ONE, h.es_rate[21:15]};
                    `IDX_ONE: byte_at = h.es_rate[14:7];
                    default: byte_at = {h.es_rate[6:0], `MARKER_ONE};
                endcase
            end
            pes_opt_pkg::S_CRC: begin
                byte_at = (i == `IDX_ZERO) ? h.crc[15:8] : h.crc[7:0];
            end
            pes_opt_pkg::S_STUFF: byte_at = `STUFF_BYTE;
            default: byte_at = 8'h00;
        endcase
    endfunction : byte_at

    always_comb begin
        logic zero_rate;
        zero_rate = (cfg_in.es_rate == `RATE_ZERO);
        next_state = state;
        next_idx = idx;
        next_hdr = hdr;
        next_valid = byte_valid_out;
        next_done = 1'b0;
        next_clamped = rate_clamped_out;
        if (state == pes_opt_pkg::S_IDLE) begin
            if (start_in) begin
                // Timestamp is taken as given for every header
                next_hdr.pts = cfg_in.pts;
                next_hdr.es_rate = zero_rate ? `RATE_MIN : cfg_in.es_rate;
                next_clamped = zero_rate;
                next_hdr.rate_on = cfg_in.rate_req
                                   || (cfg_in.es_rate > `RATE_ABOVE_9M);
                next_hdr.crc_on = cfg_in.crc_req && prev_crc_valid;
                next_hdr.crc = prev_crc;
                next_hdr.stuff = (cfg_in.stuff_cnt > `STUFF_MAX) ? `STUFF_MAX
                                 : cfg_in.stuff_cnt;
                next_state = pes_opt_pkg::S_FLAGS;
                next_idx = `IDX_ZERO;
                next_valid = 1'b1;
            end
        end else if (byte_ready_in) begin
            if (idx + `ONE_BYTE < item_len(state, hdr)) begin
                next_idx = idx + `ONE_BYTE;
            end else begin
                next_state = after(state, hdr);
                next_idx = `IDX_ZERO;
            end
            if (next_state == pes_opt_pkg::S_IDLE) begin
                next_valid = 1'b0;
                next_done = 1'b1;
            end
        end
        next_byte = byte_at(next_state, next_idx, next_hdr);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state <= pes_opt_pkg::S_IDLE;
            idx <= `IDX_ZERO;
            hdr <= '0;
            byte_out <= 8'h00;
            byte_valid_out <= 1'b0;
            header_done_out <= 1'b0;
            rate_clamped_out <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            hdr <= next_hdr;
            byte_out <= next_byte;
            byte_valid_out <= next_valid;
            header_done_out <= next_done;
            rate_clamped_out <= next_clamped;
        end
    end

    property p_ext_flag_zero;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_FLAGS)
            |-> (byte_out[0] == 1'b0 && byte_out[7:6] == `PTS_ONLY_FLAGS);
    endproperty
    a_ext_flag_zero: assert property (p_ext_flag_zero)
        else $error("flags byte has extension set or wrong stamp flags");

    property p_len_value;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_LEN)
            |-> byte_out == {2'h0, `PTS_BYTES + hdr.stuff
                + (hdr.rate_on ? `RATE_BYTES : `IDX_ZERO)
                + (hdr.crc_on ? `CRC_BYTES : `IDX_ZERO)};
    endproperty
    a_len_value: assert property (p_len_value)
        else $error("length byte does not match fields that follow");

    property p_prefix;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_PTS && idx == `IDX_ZERO)
            |-> (byte_out[7:4] == `PTS_PREFIX && byte_out[3:1] == hdr.pts[32:30]);
    endproperty
    a_prefix: assert property (p_prefix)
        else $error("timestamp prefix or top bits wrong");

    property p_pts_mid;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_PTS && idx == `IDX_ONE && byte_ready_in)
            |=> (byte_out[7:1] == hdr.pts[21:15]);
    endproperty
    a_pts_mid: assert property (p_pts_mid)
        else $error("middle timestamp piece misplaced");

    property p_markers;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_PTS
            && (idx == `IDX_ZERO || idx == `IDX_TWO || idx == `IDX_FOUR))
            |-> byte_out[0] == `MARKER_ONE;
    endproperty
    a_markers: assert property (p_markers)
        else $error("timestamp marker bit is zero");

    property p_rate_group;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_RATE && idx == `IDX_ZERO && byte_ready_in)
            ##1 byte_ready_in |=> (byte_out[0] == `MARKER_ONE && $past(byte_out, 2) >= 8'h80);
    endproperty
    a_rate_group: assert property (p_rate_group)
        else $error("rate group markers missing");

    property p_rate_nonzero;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (state == pes_opt_pkg::S_RATE) |-> (hdr.es_rate != `RATE_ZERO);
    endproperty
    a_rate_nonzero: assert property (p_rate_nonzero)
        else $error("rate field sent as zero");

    property p_rate_forced;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (state == pes_opt_pkg::S_IDLE && start_in && cfg_in.es_rate > `RATE_ABOVE_9M)
            |=> (hdr.rate_on && byte_valid_out && state == pes_opt_pkg::S_FLAGS
                && byte_out[4] == 1'b1);
    endproperty
    a_rate_forced: assert property (p_rate_forced)
        else $error("rate flag not set above the threshold");

    property p_crc_value;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_CRC)
            |-> byte_out == (idx == `IDX_ZERO ? hdr.crc[15:8] : hdr.crc[7:0]);
    endproperty
    a_crc_value: assert property (p_crc_value)
        else $error("CRC byte differs from previous packet CRC");

    property p_stuffing;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (byte_valid_out && state == pes_opt_pkg::S_STUFF)
            |-> (byte_out == `STUFF_BYTE && idx < `STUFF_MAX && hdr.stuff <= `STUFF_MAX);
    endproperty
    a_stuffing: assert property (p_stuffing)
        else $error("bad stuffing byte or count");

    property p_order;
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        (state == pes_opt_pkg::S_CRC) |=> (state == pes_opt_pkg::S_CRC
            || state == pes_opt_pkg::S_STUFF || state == pes_opt_pkg::S_IDLE);
    endproperty
    a_order: assert property (p_order)
        else $error("item after CRC out of order");

endmodule : pes_opt_framer

// *** hw/pes_opt_cfg.svh ***
// Constants for the optional header field framer
`ifndef PES_OPT_CFG_SVH
`define PES_OPT_CFG_SVH

`define PTS_ONLY_FLAGS 2'h2
`define PTS_PREFIX 4'h2
`define MARKER_ONE 1'b1
`define FLAG_OFF 1'b0
`define STUFF_BYTE 8'hFF
`define STUFF_MAX 6'h20
`define PTS_BYTES 6'h05
`define RATE_BYTES 6'h03
`define CRC_BYTES 6'h02
`define ONE_BYTE 6'h01
`define IDX_ZERO 6'h00
`define IDX_ONE 6'h01
`define IDX_TWO 6'h02
`define IDX_THREE 6'h03
`define IDX_FOUR 6'h04
`define RATE_ABOVE_9M 22'h0057E4
`define RATE_MIN 22'h000001
`define RATE_ZERO 22'h000000
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF

`endif

// *** hw/pes_opt_pkg.sv ***
// Types for the optional header field framer
package pes_opt_pkg;

    typedef enum {S_IDLE, S_FLAGS, S_LEN, S_PTS, S_RATE, S_CRC, S_STUFF} hdr_state_e;

    typedef struct packed {
        logic [32:0] pts;
        logic [21:0] es_rate;
        logic rate_req;
        logic crc_req;
        logic [5:0] stuff_cnt;
    } hdr_cfg_s;

    typedef struct packed {
        logic [32:0] pts;
        logic [21:0] es_rate;
        logic rate_on;
        logic crc_on;
        logic [15:0] crc;
        logic [5:0] stuff;
    } hdr_latch_s;

endpackage : pes_opt_pkg

// *** hw/payload_crc16.sv ***
// Running CRC16 over packet payload, held for the next header
`timescale 1ns/1ps
`include "pes_opt_cfg.svh"

module payload_crc16 (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] data_in,
    input wire logic valid_in,
    input wire logic last_in,
    output logic [15:0] prev_crc_out,
    output logic prev_valid_out
);

    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [15:0] next_prev;
    logic next_prev_valid;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ `CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc_step

    always_comb begin
        logic [15:0] upd;
        upd = valid_in ? crc_step(crc, data_in) : crc;
        next_crc = upd;
        next_prev = prev_crc_out;
        next_prev_valid = prev_valid_out;
        if (last_in) begin
            next_prev = upd;
            next_prev_valid = 1'b1;
            next_crc = `CRC_INIT;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            crc <= `CRC_INIT;
            prev_crc_out <= 16'h0000;
            prev_valid_out <= 1'b0;
        end else begin
            crc <= next_crc;
            prev_crc_out <= next_prev;
            prev_valid_out <= next_prev_valid;
        end
    end

endmodule : payload_crc16

// *** tb/pes_hdr_receiver.sv ***
// Behavioural header receiver that sinks and parses framer bytes
`timescale 1ns/1ps
module pes_hdr_receiver (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] byte_in,
    input wire logic valid_in,
    input wire logic slow_in,
    output logic ready_out,
    output logic [32:0] pts_out,
    output logic pts_valid_out,
    output logic err_out,
    output logic [7:0] stuff_out,
    output logic [7:0] cnt_out,
    output logic leak_out
);
    logic [7:0] hb [0:63];
    logic [31:0] lf;
    logic [21:0] r;
    logic e;
    int n;
    int k;
    always @(posedge sys_clk_in) begin
        pts_valid_out <= 1'b0;
        if (!reset_n_in) begin
            n = 0;
            lf <= 32'h0000ACE1;
            ready_out <= 1'b0;
            err_out <= 1'b0;
        end else begin
            lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
            ready_out <= slow_in ? lf[4] : 1'b1;
            if (valid_in && ready_out) begin
                hb[n] = byte_in;
                n = n + 1;
                if (n > 2 && n == hb[1] + 2) begin
                    pts_out <= {hb[2][3:1], hb[3], hb[4][7:1], hb[5], hb[6][7:1]};
                    e = hb[2][7:4] != 4'h2 || !hb[2][0] || !hb[4][0] || !hb[6][0];
                    k = 7;
                    if (hb[0][4]) begin
                        r = {hb[7][6:0], hb[8], hb[9][7:1]};
                        e = e || !hb[7][7] || !hb[9][0] || r == 22'h000000;
                        k = 10;
                    end
                    leak_out <= hb[0][4] && (r > 22'h0057E4);
                    if (hb[0][1]) k = k + 2;
                    stuff_out <= 8'(hb[1] + 2 - k);
                    err_out <= e;
                    cnt_out <= 8'(n);
                    pts_valid_out <= 1'b1;
                    n = 0;
                end
            end
        end
    end
endmodule : pes_hdr_receiver

// *** tb/pes_header_optional_fields_test.sv ***
// Self-checking bench for the optional header field framer
`timescale 1ns/1ps
`include "pes_opt_cfg.svh"
module pes_header_optional_fields_test;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    pes_opt_pkg::hdr_cfg_s cfg_in = '0;
    logic byte_ready_in;
    logic [7:0] payload_byte_in = 8'h00;
    logic payload_valid_in = 1'b0;
    logic payload_last_in = 1'b0;
    logic slow_in = 1'b0;
    logic [7:0] byte_out;
    logic byte_valid_out, header_done_out, rate_clamped_out, pts_valid_out, err_out;
    logic [32:0] pts_out;
    logic [7:0] stuff_out, cnt_out;
    logic [31:0] seed = 32'h00000011;
    logic [15:0] run_crc = `CRC_INIT;
    logic [15:0] prev_crc = 16'h0000;
    logic have_crc = 1'b0;
    logic [7:0] exp [0:63];
    int elen, est;
    logic exp_leak;
    logic leak_out;
    int error_cnt = 0;
    int compares = 0;

    pes_opt_framer pes_opt_framer_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .start_in(start_in), .cfg_in(cfg_in), .byte_ready_in(byte_ready_in),
        .payload_byte_in(payload_byte_in), .payload_valid_in(payload_valid_in),
        .payload_last_in(payload_last_in), .byte_out(byte_out), .byte_valid_out(byte_valid_out),
        .header_done_out(header_done_out), .rate_clamped_out(rate_clamped_out));
    pes_hdr_receiver pes_hdr_receiver_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .byte_in(byte_out), .valid_in(byte_valid_out), .slow_in(slow_in),
        .ready_out(byte_ready_in), .pts_out(pts_out), .pts_valid_out(pts_valid_out),
        .err_out(err_out), .stuff_out(stuff_out), .cnt_out(cnt_out), .leak_out(leak_out));

    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        error_cnt++;
        conclude();
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) x = x[15] ? ((x << 1) ^ `CRC_POLY) : (x << 1);
        return x;
    endfunction : crc_step
    function automatic pes_opt_pkg::hdr_cfg_s rcfg();
        pes_opt_pkg::hdr_cfg_s c;
        c.pts = 33'({rnd(), rnd()});
        c.es_rate = 22'(rnd() >> (rnd() & 32'h0000001F));
        c.rate_req = 1'(rnd());
        c.crc_req = 1'(rnd());
        c.stuff_cnt = 6'(rnd() % 41);
        return c;
    endfunction : rcfg

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        compares++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %0t: got %0h expected %0h", $time, seen, want);
        end
    endtask : chk
    task automatic conclude();
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic build(input pes_opt_pkg::hdr_cfg_s c);
        logic [21:0] r;
        logic ron, con;
        r = (c.es_rate == `RATE_ZERO) ? `RATE_MIN : c.es_rate;
        ron = c.rate_req | (c.es_rate > `RATE_ABOVE_9M);
        con = c.crc_req & have_crc;
        exp_leak = ron && (r > `RATE_ABOVE_9M);
        est = (c.stuff_cnt > `STUFF_MAX) ? 32 : c.stuff_cnt;
        exp[0] = {2'h2, 1'b0, ron, 2'h0, con, 1'b0};
        exp[1] = 8'(5 + 3 * ron + 2 * con + est);
        exp[2] = {4'h2, c.pts[32:30], 1'b1};
        exp[3] = c.pts[29:22];
        exp[4] = {c.pts[21:15], 1'b1};
        exp[5] = c.pts[14:7];
        exp[6] = {c.pts[6:0], 1'b1};
        elen = 7;
        if (ron) begin
            exp[7] = {1'b1, r[21:15]};
            exp[8] = r[14:7];
            exp[9] = {r[6:0], 1'b1};
            elen = 10;
        end
        if (con) begin
            exp[elen] = prev_crc[15:8];
            exp[elen + 1] = prev_crc[7:0];
            elen = elen + 2;
        end
        for (int i = 0; i < est; i++) exp[elen + i] = `STUFF_BYTE;
        elen = elen + est;
    endtask : build
    task automatic pay(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            @(posedge sys_clk_in);
            payload_byte_in <= d;
            payload_valid_in <= 1'b1;
            payload_last_in <= (i == n - 1);
            run_crc = crc_step(run_crc, d);
        end
        @(posedge sys_clk_in);
        payload_valid_in <= 1'b0;
        payload_last_in <= 1'b0;
        prev_crc = run_crc;
        run_crc = `CRC_INIT;
        have_crc = 1'b1;
    endtask : pay
    task automatic hdr(input pes_opt_pkg::hdr_cfg_s c, input logic slow, input logic poke);
        int t;
        build(c);
        @(posedge sys_clk_in);
        slow_in <= slow;
        start_in <= 1'b1;
        cfg_in <= c;
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        if (poke) begin
            repeat (3) @(posedge sys_clk_in);
            start_in <= 1'b1;
            cfg_in <= ~c;
            @(posedge sys_clk_in);
            start_in <= 1'b0;
        end
        t = 0;
        do begin
            @(posedge sys_clk_in);
            #1;
            t++;
        end while (header_done_out !== 1'b1 && t < 3000);
        chk(header_done_out, 1'b1);
        chk(cnt_out, 8'(elen));
        chk(pes_hdr_receiver_inst.hb[0], exp[0]);
        chk(pes_hdr_receiver_inst.hb[1], exp[1]);
        for (int i = 2; i < elen; i++) chk(pes_hdr_receiver_inst.hb[i], exp[i]);
        chk(pts_out, c.pts);
        chk(err_out, 1'b0);
        chk(stuff_out, 8'(est));
        chk(pts_valid_out, 1'b1);
        chk(leak_out, exp_leak);
        chk(rate_clamped_out, c.es_rate == `RATE_ZERO);
        @(posedge sys_clk_in);
        #1;
        chk({header_done_out, byte_valid_out}, 2'h0);
    endtask : hdr

    initial begin
        pes_opt_pkg::hdr_cfg_s c;
        repeat (12) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        c = '0;
        c.pts = 33'h1ABCD1234;
        c.crc_req = 1'b1;
        c.es_rate = 22'h000001;
        hdr(c, 1'b0, 1'b0);
        pay(5);
        c.es_rate = 22'h0057E5;
        c.pts = 33'h0FFFFFFFF;
        hdr(c, 1'b0, 1'b1);
        c.es_rate = `RATE_ABOVE_9M;
        hdr(c, 1'b1, 1'b0);
        c.es_rate = `RATE_ZERO;
        c.rate_req = 1'b1;
        c.stuff_cnt = 6'h20;
        hdr(c, 1'b1, 1'b0);
        c.stuff_cnt = 6'h3F;
        hdr(c, 1'b0, 1'b0);
        for (int i = 0; i < 24; i++) begin
            if (rnd() & 32'h00000001) pay(1 + rnd() % 6);
            hdr(rcfg(), 1'(rnd()), 1'b0);
        end
        @(posedge sys_clk_in);
        start_in <= 1'b1;
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
        chk({byte_valid_out, header_done_out, rate_clamped_out}, 3'h0);
        @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        have_crc = 1'b0;
        run_crc = `CRC_INIT;
        hdr(c, 1'b0, 1'b0);
        conclude();
    end
endmodule : pes_header_optional_fields_test
